/* File: src/ces_consts.vh */
// constants for the chop and excitation sequencer
// assumes a single 250 MHz master clock; included by bare name
`ifndef CES_CONSTS_VH
`define CES_CONSTS_VH

// ----------------------------------------------------------------------
// chop field encodings
// ----------------------------------------------------------------------
`define CES_CHOP_OFF 2'b00
`define CES_CHOP_INT 2'b01
`define CES_CHOP_AC2 2'b10
`define CES_CHOP_AC4 2'b11

// ----------------------------------------------------------------------
// reset values and field widths
// ----------------------------------------------------------------------
`define CES_DELAY_RESET 4'h1
`define CES_CHOP_RESET 2'b00
`define CES_DELAY_W 4
`define CES_CHOP_W 2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CES_CLK_MHZ 250
`define CES_DELAY_UNIT_NS 50000
`define CES_DEAD_NS 200

`endif

/* File: src/ces_excite_drive.v */
// break-before-make driver for the two excitation polarity signals
// assumes phase changes at most once per conversion, from the sequencer
`timescale 1ns/10ps
`include "ces_consts.vh"

module ces_excite_drive #(
  parameter DEAD_CYCLES = (`CES_DEAD_NS * `CES_CLK_MHZ + 999) / 1000
) (
  input wire mclk,
  input wire reset_n,
  input wire phase,
  output reg excite_phase_a,
  output reg excite_phase_b
);

  reg phase_seen;
  reg [15:0] gap_cnt;

  // ----------------------------------------------------------------------
  // dead-time gap on every polarity change
  // ----------------------------------------------------------------------
  // both drives fall first, then the new one rises after the gap, so the
  // external bridge switches never conduct across the supply
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_seen <= 1'b0;
      gap_cnt <= 16'h0000;
      excite_phase_a <= 1'b1;
      excite_phase_b <= 1'b0;
    end else if (phase != phase_seen) begin
      phase_seen <= phase;
      gap_cnt <= DEAD_CYCLES[15:0];
      excite_phase_a <= 1'b0;
      excite_phase_b <= 1'b0;
    end else if (gap_cnt != 16'h0000) begin
      gap_cnt <= gap_cnt - 16'h0001;
    end else begin
      excite_phase_a <= ~phase_seen;
      excite_phase_b <= phase_seen;
    end
  end

endmodule // ces_excite_drive

/* File: src/ces_sequencer.v */
// conversion sequencer: start delay, global chop and bridge excitation
// assumes the filter answers each conv_start with one raw_valid pulse,
// and that start_pin comes asynchronously from a device pin
`timescale 1ns/10ps
`include "ces_consts.vh"

// Functional notes
// - programmable wait before the first conversion after start and before each chop conversion, 50 us after reset
// - delay code 0001 selects the 50 us reference wait
// - longer waits add directly to result latency
// - chop or excitation: first result after two conversions, then one each
// - chop mode inverts input polarity on every successive conversion
// - first raw conversion after start yields no output in chop
// - chop output is normal minus reversed, halved, once per new conversion
// - excitation drives normal then reversed polarity in lockstep with conversions
// - reversed phase inverts reference; normal and reversed results subtracted
// - the two drive outputs never active together; break-before-make gap
// - drive outputs toggle at most once per conversion period
// - chop field 10 selects two-wire, 11 four-wire excitation
// - pins 0,1 carry phases a,b; four-wire adds pins 2,3 likewise
// - ready output high at conversion start, low when result ready; a back-to-back plain start sees it rise one cycle later
// - plain mode: following results one data period apart
module ces_sequencer #(
  parameter DATA_W = 24,
  parameter DELAY_UNIT_CYCLES = `CES_DELAY_UNIT_NS * `CES_CLK_MHZ / 1000,
  parameter DEAD_CYCLES = (`CES_DEAD_NS * `CES_CLK_MHZ + 999) / 1000
) (
  input wire mclk,
  input wire reset_n,
  input wire start_pin,
  input wire cfg_we,
  input wire [`CES_DELAY_W-1:0] cfg_delay,
  input wire [`CES_CHOP_W-1:0] cfg_chop,
  input wire raw_valid,
  input wire [DATA_W-1:0] raw_data,
  output reg conv_start,
  output wire input_invert,
  output wire ref_invert,
  output reg result_valid,
  output reg [DATA_W-1:0] result_data,
  output reg result_ready_n,
  output reg [`CES_DELAY_W-1:0] delay_code,
  output reg [`CES_CHOP_W-1:0] chop_mode,
  output wire gen_pin_0,
  output wire gen_pin_0_oe,
  output wire gen_pin_1,
  output wire gen_pin_1_oe,
  output wire gen_pin_2,
  output wire gen_pin_2_oe,
  output wire gen_pin_3,
  output wire gen_pin_3_oe
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_CONV = 2'd2;

  reg [1:0] state;
  reg [31:0] wait_cnt;
  reg phase;
  reg first_done;
  reg [DATA_W-1:0] prev_raw;
  reg start_meta;
  reg start_sync;
  reg start_last;
  wire run;
  wire run_rise;
  wire chop_on;
  wire ac_on;
  wire excite_a;
  wire excite_b;
  wire [DATA_W:0] diff;
  wire [DATA_W-1:0] half;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // wait length: code 0 none, then 50 us doubling per step
  function [31:0] wait_cycles;
    input [`CES_DELAY_W-1:0] code;
    begin
      if (code == 4'h0) begin
        wait_cycles = 32'h0000_0000;
      end else begin
        wait_cycles = DELAY_UNIT_CYCLES[31:0] << (code - 4'h1);
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------------
  // a new delay code takes effect at the next wait load, not mid-count; a new chop field at once
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      delay_code <= `CES_DELAY_RESET;
      chop_mode <= `CES_CHOP_RESET;
    end else if (cfg_we) begin
      delay_code <= cfg_delay;
      chop_mode <= cfg_chop;
    end
  end

  // ----------------------------------------------------------------------
  // start pin synchroniser
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_last <= 1'b0;
    end else begin
      start_meta <= start_pin;
      start_sync <= start_meta;
      start_last <= start_sync;
    end
  end

  assign run = start_sync;
  assign run_rise = start_sync & ~start_last;
  assign chop_on = (chop_mode != `CES_CHOP_OFF);
  assign ac_on = chop_mode[1];

  // chop math: normal minus reversed, arithmetic halving
  assign diff = phase ? ({prev_raw[DATA_W-1], prev_raw} - {raw_data[DATA_W-1], raw_data})
                      : ({raw_data[DATA_W-1], raw_data} - {prev_raw[DATA_W-1], prev_raw});
  assign half = diff[DATA_W:1];

  // ----------------------------------------------------------------------
  // conversion sequence
  // ----------------------------------------------------------------------
  // a rising start always restarts at normal phase; a falling start lets
  // the conversion in flight finish before going idle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      wait_cnt <= 32'h0000_0000;
      phase <= 1'b0;
      first_done <= 1'b0;
      prev_raw <= {DATA_W{1'b0}};
      conv_start <= 1'b0;
      result_valid <= 1'b0;
      result_data <= {DATA_W{1'b0}};
      result_ready_n <= 1'b1;
    end else begin
      conv_start <= 1'b0;
      result_valid <= 1'b0;
      if (run_rise) begin
        state <= ST_WAIT;
        wait_cnt <= wait_cycles(delay_code);
        phase <= 1'b0;
        first_done <= 1'b0;
        result_ready_n <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            phase <= 1'b0;
          end
          ST_WAIT: begin
            // the wait sits in front of the conversion, so it adds to latency
            if (wait_cnt == 32'h0000_0000) begin
              conv_start <= 1'b1;
              result_ready_n <= 1'b1;
              state <= ST_CONV;
            end else begin
              wait_cnt <= wait_cnt - 32'h0000_0001;
            end
          end
          ST_CONV: begin
            // ready rises once the filter has taken the start, so a back-to-back
            // result in plain mode still shows ready low for one cycle
            if (conv_start) begin
              result_ready_n <= 1'b1;
            end
            if (raw_valid) begin
              prev_raw <= raw_data;
              first_done <= 1'b1;
              if (!chop_on) begin
                result_data <= raw_data;
                result_valid <= 1'b1;
                result_ready_n <= 1'b0;
              end else if (first_done) begin
                result_data <= half;
                result_valid <= 1'b1;
                result_ready_n <= 1'b0;
              end
              // first chop conversion is withheld: no result above
              if (!run) begin
                state <= ST_IDLE;
                phase <= 1'b0;
              end else if (chop_on) begin
                // flip polarity once per conversion and resettle first
                phase <= ~phase;
                wait_cnt <= wait_cycles(delay_code);
                state <= ST_WAIT;
              end else begin
                // plain mode runs back to back at the data rate
                conv_start <= 1'b1;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // internal polarity steering
  assign input_invert = phase & (chop_mode == `CES_CHOP_INT);
  assign ref_invert = phase & ac_on;

  // ----------------------------------------------------------------------
  // excitation drive
  // ----------------------------------------------------------------------
  // limitation: the dead gap must be shorter than the start wait, else the
  // conversion begins while the bridge is still unpowered
  ces_excite_drive #(
    .DEAD_CYCLES(DEAD_CYCLES)
  ) u_drive (
    .mclk(mclk),
    .reset_n(reset_n),
    .phase(phase & ac_on),
    .excite_phase_a(excite_a),
    .excite_phase_b(excite_b)
  );

  // pin mapping per excitation width
  assign gen_pin_0 = ac_on & excite_a;
  assign gen_pin_1 = ac_on & excite_b;
  assign gen_pin_2 = (chop_mode == `CES_CHOP_AC4) & excite_a;
  assign gen_pin_3 = (chop_mode == `CES_CHOP_AC4) & excite_b;
  assign gen_pin_0_oe = ac_on;
  assign gen_pin_1_oe = ac_on;
  assign gen_pin_2_oe = (chop_mode == `CES_CHOP_AC4);
  assign gen_pin_3_oe = (chop_mode == `CES_CHOP_AC4);

endmodule // ces_sequencer

/* File: verif/ces_sequencer_properties.sv */
// port checks for the chop and excitation sequencer
// assumes the bench sets DEAD_CYCLES 3 and a wait of 20 or more cycles
`timescale 1ns/10ps
module ces_sequencer_properties (
  input wire mclk,
  input wire reset_n,
  input wire raw_valid,
  input wire conv_start,
  input wire input_invert,
  input wire ref_invert,
  input wire result_valid,
  input wire result_ready_n,
  input wire [1:0] chop_mode,
  input wire gen_pin_0,
  input wire gen_pin_1,
  input wire gen_pin_2,
  input wire gen_pin_3,
  input wire gen_pin_0_oe,
  input wire gen_pin_1_oe,
  input wire gen_pin_2_oe,
  input wire gen_pin_3_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // short gap, then a long quiet stretch on phase b
  sequence gap_s; !gen_pin_1 [*2]; endsequence
  sequence hold_s; !$fell(gen_pin_1) [*8]; endsequence
  a_no_overlap: assert property (!(gen_pin_0 && gen_pin_1)) else $error("drives overlap");
  a_break_gap: assert property ($fell(gen_pin_0) |-> gap_s) else $error("no dead gap");
  a_slow_toggle: assert property ($rose(gen_pin_1) |=> hold_s) else $error("drive too fast");
  a_four_mirror: assert property (chop_mode == 2'b11 |->
    gen_pin_2 == gen_pin_0 && gen_pin_3 == gen_pin_1) else $error("four-wire mirror wrong");
  a_two_wire_oe: assert property (chop_mode == 2'b10 |->
    gen_pin_0_oe && gen_pin_1_oe && !gen_pin_2_oe && !gen_pin_3_oe) else $error("two-wire enables wrong");
  a_four_wire_oe: assert property (chop_mode == 2'b11 |->
    gen_pin_0_oe && gen_pin_1_oe && gen_pin_2_oe && gen_pin_3_oe) else $error("four-wire enables wrong");
  a_pins_quiet: assert property (!chop_mode[1] |-> !gen_pin_0_oe && !gen_pin_1_oe && !gen_pin_0)
    else $error("pins driven outside excitation");
  a_invert_mode: assert property (input_invert |-> chop_mode == 2'b01) else $error("input invert");
  a_ref_mode: assert property (ref_invert |-> chop_mode[1] && !input_invert) else $error("ref invert");
  a_phase_lock: assert property (chop_mode[1] && $stable(ref_invert) |->
    (ref_invert ? !gen_pin_0 : !gen_pin_1)) else $error("drive out of phase");
  a_ready_result: assert property (result_valid |-> !result_ready_n && $past(raw_valid))
    else $error("result without ready");
  a_ready_start: assert property (conv_start |=> result_ready_n) else $error("ready low after start");
  a_chop_wait: assert property (chop_mode != 2'b00 && raw_valid |=> !conv_start [*8])
    else $error("no wait before conversion");
endmodule // ces_sequencer_properties
bind ces_sequencer ces_sequencer_properties chk_i (
  .mclk(mclk),
  .reset_n(reset_n),
  .raw_valid(raw_valid),
  .conv_start(conv_start),
  .input_invert(input_invert),
  .ref_invert(ref_invert),
  .result_valid(result_valid),
  .result_ready_n(result_ready_n),
  .chop_mode(chop_mode),
  .gen_pin_0(gen_pin_0),
  .gen_pin_1(gen_pin_1),
  .gen_pin_2(gen_pin_2),
  .gen_pin_3(gen_pin_3),
  .gen_pin_0_oe(gen_pin_0_oe),
  .gen_pin_1_oe(gen_pin_1_oe),
  .gen_pin_2_oe(gen_pin_2_oe),
  .gen_pin_3_oe(gen_pin_3_oe)
);

/* File: verif/ces_bridge_model.sv */
// stand-in for the bridge switches and the filter behind them
// assumes phase b drive reverses the bridge; answers each conv_start once
`timescale 1ns/10ps
module ces_bridge_model #(
  parameter SIG = 24'sd1000,
  parameter OFS = 24'sd37
) (
  input wire mclk,
  input wire conv_start,
  input wire input_invert,
  input wire gen_pin_1,
  input wire gen_pin_1_oe,
  output reg raw_valid = 1'b0,
  output reg [23:0] raw_data = 24'h0
);
  reg [3:0] cnt = 4'h0;
  reg slow = 1'b0;
  reg rev = 1'b0;
  // quick and slow answers alternate; data churns when not valid
  always @(posedge mclk) begin
    raw_valid <= 1'b0;
    raw_data <= ~raw_data;
    if (cnt != 4'h0) cnt <= cnt - 4'h1;
    if (conv_start) begin
      cnt <= slow ? 4'h9 : 4'h2;
      slow <= !slow;
      rev <= input_invert | (gen_pin_1 & gen_pin_1_oe);
    end else if (cnt == 4'h1) begin
      raw_valid <= 1'b1;
      raw_data <= rev ? OFS - SIG : OFS + SIG;
    end
  end
endmodule // ces_bridge_model

/* File: verif/ces_sequencer_bench.sv */
// self-checking bench for the chop and excitation sequencer
// assumes short parameters: 20-cycle delay unit, 3-cycle dead time
`timescale 1ns/10ps
module ces_sequencer_bench;
  reg mclk = 0, reset_n = 0, start_pin = 0, cfg_we = 0, clr = 0;
  reg [3:0] cfg_delay = 4'h0;
  reg [1:0] cfg_chop = 2'b00;
  wire raw_valid, conv_start, input_invert, ref_invert, result_valid, result_ready_n;
  wire [23:0] raw_data, result_data;
  wire [3:0] delay_code;
  wire [1:0] chop_mode;
  wire gen_pin_0, gen_pin_1, gen_pin_2, gen_pin_3;
  wire gen_pin_0_oe, gen_pin_1_oe, gen_pin_2_oe, gen_pin_3_oe;
  int err_count = 0, check_count = 0, cyc = 0, starts = 0, nres = 0, lead = 0;
  int t0, t1, t2;
  logic [23:0] exp_data;
  logic [23:0] rexp [4] = '{24'd1037, 24'd1000, 24'd1000, 24'd1000};
  int rlead [4] = '{1, 2, 2, 2};

  ces_sequencer #(.DELAY_UNIT_CYCLES(20), .DEAD_CYCLES(3)) uut (
    .mclk(mclk),
    .reset_n(reset_n),
    .start_pin(start_pin),
    .cfg_we(cfg_we),
    .cfg_delay(cfg_delay),
    .cfg_chop(cfg_chop),
    .raw_valid(raw_valid),
    .raw_data(raw_data),
    .conv_start(conv_start),
    .input_invert(input_invert),
    .ref_invert(ref_invert),
    .result_valid(result_valid),
    .result_data(result_data),
    .result_ready_n(result_ready_n),
    .delay_code(delay_code),
    .chop_mode(chop_mode),
    .gen_pin_0(gen_pin_0),
    .gen_pin_0_oe(gen_pin_0_oe),
    .gen_pin_1(gen_pin_1),
    .gen_pin_1_oe(gen_pin_1_oe),
    .gen_pin_2(gen_pin_2),
    .gen_pin_2_oe(gen_pin_2_oe),
    .gen_pin_3(gen_pin_3),
    .gen_pin_3_oe(gen_pin_3_oe)
  );
  ces_bridge_model far_i (
    .mclk(mclk),
    .conv_start(conv_start),
    .input_invert(input_invert),
    .gen_pin_1(gen_pin_1),
    .gen_pin_1_oe(gen_pin_1_oe),
    .raw_valid(raw_valid),
    .raw_data(raw_data)
  );

  always #2 mclk = ~mclk;

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one start: write config, time the first conversion, take three results
  task automatic run(input logic [1:0] m, input logic [3:0] d, output int t);
    cfg_chop <= m;
    cfg_delay <= d;
    cfg_we <= 1;
    clr <= 1;
    @(posedge mclk);
    cfg_we <= 0;
    clr <= 0;
    start_pin <= 1;
    t = 0;
    do begin @(posedge mclk); t++; end while (conv_start !== 1'b1);
    while (nres < 3) @(posedge mclk);
    start_pin <= 0;
    repeat (80) @(posedge mclk);
  endtask

  // result monitor; also cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
    if (clr) begin
      starts <= 0;
      nres <= 0;
    end else begin
      if (conv_start) starts <= starts + 1;
      if (result_valid) begin
        nres <= nres + 1;
        if (nres == 0) lead <= starts;
        chk("result_data", exp_data, result_data);
      end
    end
  end

  initial begin
    repeat (11) @(posedge mclk);
    chk("reset state", 24'h44, {result_ready_n, delay_code, chop_mode});
    @(posedge mclk);
    reset_n <= 1;
    // one row per chop field code
    for (int i = 0; i < 4; i++) begin
      exp_data = rexp[i];
      run(i[1:0], 4'h1, t0);
      chk("first lead", 24'(rlead[i]), 24'(lead));
    end
    chk("rest pins", 24'h5, {gen_pin_3, gen_pin_2, gen_pin_1, gen_pin_0});
    // reset in mid-run: outputs fall back at once, later runs start clean
    cfg_chop <= 2'b11;
    cfg_we <= 1;
    @(posedge mclk);
    cfg_we <= 0;
    start_pin <= 1;
    repeat (40) @(posedge mclk);
    reset_n <= 0;
    start_pin <= 0;
    @(posedge mclk);
    chk("mid reset cfg", 24'h44, {result_ready_n, delay_code, chop_mode});
    chk("reset pins", 24'h0, {conv_start, gen_pin_1, gen_pin_0, gen_pin_0_oe, gen_pin_2_oe});
    repeat (10) @(posedge mclk);
    reset_n <= 1;
    // start waits must add directly to the first conversion time
    exp_data = rexp[0];
    run(2'b00, 4'h0, t0);
    run(2'b00, 4'h1, t1);
    run(2'b00, 4'h2, t2);
    chk("wait code 1", 24'd20, 24'(t1 - t0));
    chk("wait code 2", 24'd20, 24'(t2 - t1));
    conclude();
  end
endmodule // ces_sequencer_bench
